/* File: verilog/sbsc_consts.vh */
// constants for the burst and sleep controller
`ifndef SBSC_CONSTS_VH
`define SBSC_CONSTS_VH
`define SBSC_ADDR_W          20
`define SBSC_DATA_W          36
`define SBSC_BYTE_W          4
`define SBSC_BURST_W         2
`define SBSC_BURST_WRAP      2'h3
`define SBSC_SLEEP_ENTRY_CYC 2
`define SBSC_SLEEP_RECOV_CYC 2
`define SBSC_ST_ACTIVE       2'h0
`define SBSC_ST_ENTRY        2'h1
`define SBSC_ST_ASLEEP       2'h2
`define SBSC_ST_WAKE         2'h3
`define SBSC_CNT_RESET       2'h0
`endif

/* File: verilog/sbsc_burst_gen.v */
// two-bit burst address generator
`timescale 1ns/1ns
`include "sbsc_consts.vh"
module sbsc_burst_gen
(
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    input  wire       hold_in,
    input  wire       load_in,
    input  wire       advance_in,
    input  wire       burst_order_sel_in,
    input  wire [1:0] start_in,
    output wire [1:0] addr_low_out
);
    reg [1:0] start_r;
    reg [1:0] count_r;
    reg [1:0] count_nxt;
    wire [1:0] beat_nxt;

    function [1:0] sbsc_seq;
        input [1:0] base;
        input [1:0] beat;
        input       interleave;
        begin
            if (interleave)
                sbsc_seq = base ^ beat;
            else
                sbsc_seq = base + beat;
        end
    endfunction

    always @*
    begin
        count_nxt = count_r;
        if (!hold_in && load_in)
            count_nxt = `SBSC_CNT_RESET;
        else if (!hold_in && advance_in)
            count_nxt = count_r + 2'h1;
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            start_r <= 2'h0;
            count_r <= 2'h0;
        end
        else
        begin
            count_r <= count_nxt;
            if (!hold_in && load_in)
                start_r <= start_in;
        end
    end

    // continue beat uses the count after the beats already issued
    assign beat_nxt     = count_r + 2'h1;
    assign addr_low_out = sbsc_seq(start_r, beat_nxt, burst_order_sel_in);
endmodule

/* File: verilog/sbsc_ctrl.v */
// flow-through sram core with burst generator and sleep control
// Function
// - load_advance_ctl high steps counter; access uses its address
// - load_advance_ctl low loads burst start from address pins
// - counter wraps after four beats; fifth beat repeats start
// - burst_order_sel high gives interleaved order, start xor beat
// - burst_order_sel low gives linear order, increment modulo four
// - back-to-back reads and writes on every cycle, no idles
// - sleep_req high enters sleep three cycles later
// - sleep keeps memory contents and internal state
// - sleep_req low resumes operation after two cycle wake-up
// - asleep acts deselected, inputs ignored, data outputs released
// - asleep lasts one cycle less than sleep_req high
// - burst counter is two bits, upper address held as loaded
// - burst-continue after a selected load advances counter; read/write as first beat, byte writes per beat
// - address/control on first edge, write data at second edge
`timescale 1ns/1ns
`include "sbsc_consts.vh"
module sbsc_ctrl
#(
    parameter ADDR_W = `SBSC_ADDR_W,
    parameter DATA_W = `SBSC_DATA_W,
    parameter BYTE_W = `SBSC_BYTE_W,
    parameter DEPTH  = 1024
)
(
    input  wire              core_clk_in,
    input  wire              rst_n_in,
    input  wire [ADDR_W-1:0] addr_in,
    input  wire              load_advance_ctl_in,
    input  wire              write_n_in,
    input  wire [BYTE_W-1:0] byte_wr_n_in,
    input  wire              chip_en1_n_in,
    input  wire              chip_en2_in,
    input  wire              chip_en3_n_in,
    input  wire              out_en_n_in,
    input  wire              clk_en_n_in,
    input  wire              burst_order_sel_in,
    input  wire              sleep_req_in,
    input  wire [DATA_W-1:0] dq_in,
    output reg  [DATA_W-1:0] dq_out,
    output reg               dq_oe_out,
    output reg               asleep_out
);
    localparam LANE_W  = DATA_W / BYTE_W;
    localparam ST_ACT  = `SBSC_ST_ACTIVE;
    localparam ST_ENT  = `SBSC_ST_ENTRY;
    localparam ST_SLP  = `SBSC_ST_ASLEEP;
    localparam ST_WAKE = `SBSC_ST_WAKE;
    localparam ROW_W   = $clog2(DEPTH);
    localparam ENT_LD  = `SBSC_SLEEP_ENTRY_CYC - 1;
    localparam WAK_LD  = `SBSC_SLEEP_RECOV_CYC - 1;

    reg [DATA_W-1:0] mem_r [0:DEPTH-1];

    // array row: low address bits, depth a power of two
    function [ROW_W-1:0] sbsc_row;
        input [ADDR_W-1:0] a;
        begin
            sbsc_row = a[ROW_W-1:0];
        end
    endfunction

    // pin synchronisers
    reg              zz_s1_r;
    reg              zz_s2_r;
    reg              adv_s1_r;
    reg              adv_s2_r;
    reg              wr_n_s1_r;
    reg              wr_n_s2_r;
    reg [BYTE_W-1:0] be_n_s1_r;
    reg [BYTE_W-1:0] be_n_s2_r;
    reg [2:0]        ce_s1_r;
    reg [2:0]        ce_s2_r;
    reg              oe_n_s1_r;
    reg              oe_n_s2_r;
    reg              cke_n_s1_r;
    reg              cke_n_s2_r;
    reg              lbo_s1_r;
    reg              lbo_s2_r;
    reg [ADDR_W-1:0] addr_s1_r;
    reg [ADDR_W-1:0] addr_s2_r;
    reg [DATA_W-1:0] dq_s1_r;
    reg [DATA_W-1:0] dq_s2_r;

    reg [1:0]        state_r;
    reg [1:0]        state_nxt;
    reg [1:0]        tmr_r;
    reg [1:0]        tmr_nxt;

    // burst and late-write pipeline state
    reg [ADDR_W-3:0] addr_hi_r;
    reg              burst_rd_r;
    reg              burst_act_r;
    reg              wr_pend_r;
    reg [ADDR_W-1:0] wr_addr_r;
    reg [BYTE_W-1:0] wr_be_n_r;

    wire             sleeping;
    wire             hold;
    wire             selected;
    wire             load_cyc;
    wire             load_sel;
    wire             adv_cyc;
    wire [1:0]       addr_low;
    wire [ADDR_W-1:0] acc_addr;
    wire             do_write;
    wire             do_read;
    wire             wr_any;

    // drivers off from the edge that enters sleep
    assign sleeping = (state_nxt == ST_SLP);
    // inputs ignored while asleep, and clock-enable suspends
    assign hold     = cke_n_s2_r || (state_r == ST_SLP);
    assign selected = !ce_s2_r[0] && ce_s2_r[1] && !ce_s2_r[2];
    assign load_cyc = !hold && !adv_s2_r;
    assign load_sel = load_cyc && selected;
    assign adv_cyc  = !hold && adv_s2_r && burst_act_r;
    assign wr_any   = ~&be_n_s2_r;

    sbsc_burst_gen i_sbsc_burst_gen
    (
        .core_clk_in        (core_clk_in),
        .rst_n_in           (rst_n_in),
        .hold_in            (hold),
        .load_in            (load_sel),
        .advance_in         (adv_cyc),
        .burst_order_sel_in (lbo_s2_r),
        .start_in           (addr_s2_r[1:0]),
        .addr_low_out       (addr_low)
    );

    // upper bits stay as loaded; low bits from counter
    assign acc_addr = {addr_hi_r, addr_low};
    assign do_read  = adv_cyc && burst_rd_r;
    assign do_write = wr_pend_r && !cke_n_s2_r;

    // sleep entry and wake-up sequencing
    always @*
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        case (state_r)
            ST_ACT:
            begin
                if (zz_s2_r)
                begin
                    state_nxt = ST_ENT;
                    tmr_nxt   = ENT_LD[1:0];
                end
            end
            ST_ENT:
            begin
                if (!zz_s2_r)
                    state_nxt = ST_ACT;
                else if (tmr_r == 2'h1)
                    state_nxt = ST_SLP;
                else
                    tmr_nxt = tmr_r - 2'h1;
            end
            ST_SLP:
            begin
                if (!zz_s2_r)
                begin
                    state_nxt = ST_WAKE;
                    tmr_nxt   = WAK_LD[1:0];
                end
            end
            ST_WAKE:
            begin
                if (zz_s2_r)
                    state_nxt = ST_SLP;
                else if (tmr_r == 2'h1)
                    state_nxt = ST_ACT;
                else
                    tmr_nxt = tmr_r - 2'h1;
            end
            default:
            begin
                state_nxt = ST_ACT;
                tmr_nxt   = 2'h0;
            end
        endcase
    end

    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            zz_s1_r     <= 1'b0;
            zz_s2_r     <= 1'b0;
            adv_s1_r    <= 1'b0;
            adv_s2_r    <= 1'b0;
            wr_n_s1_r   <= 1'b1;
            wr_n_s2_r   <= 1'b1;
            be_n_s1_r   <= {BYTE_W{1'b1}};
            be_n_s2_r   <= {BYTE_W{1'b1}};
            ce_s1_r     <= 3'h5;
            ce_s2_r     <= 3'h5;
            oe_n_s1_r   <= 1'b1;
            oe_n_s2_r   <= 1'b1;
            cke_n_s1_r  <= 1'b1;
            cke_n_s2_r  <= 1'b1;
            lbo_s1_r    <= 1'b0;
            lbo_s2_r    <= 1'b0;
            addr_s1_r   <= {ADDR_W{1'b0}};
            addr_s2_r   <= {ADDR_W{1'b0}};
            dq_s1_r     <= {DATA_W{1'b0}};
            dq_s2_r     <= {DATA_W{1'b0}};
            state_r     <= ST_ACT;
            tmr_r       <= 2'h0;
            addr_hi_r   <= {(ADDR_W-2){1'b0}};
            burst_rd_r  <= 1'b0;
            burst_act_r <= 1'b0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= {ADDR_W{1'b0}};
            wr_be_n_r   <= {BYTE_W{1'b1}};
            dq_out      <= {DATA_W{1'b0}};
            dq_oe_out   <= 1'b0;
            asleep_out  <= 1'b0;
        end
        else
        begin
            zz_s1_r    <= sleep_req_in;
            zz_s2_r    <= zz_s1_r;
            adv_s1_r   <= load_advance_ctl_in;
            adv_s2_r   <= adv_s1_r;
            wr_n_s1_r  <= write_n_in;
            wr_n_s2_r  <= wr_n_s1_r;
            be_n_s1_r  <= byte_wr_n_in;
            be_n_s2_r  <= be_n_s1_r;
            ce_s1_r    <= {chip_en3_n_in, chip_en2_in, chip_en1_n_in};
            ce_s2_r    <= ce_s1_r;
            oe_n_s1_r  <= out_en_n_in;
            oe_n_s2_r  <= oe_n_s1_r;
            cke_n_s1_r <= clk_en_n_in;
            cke_n_s2_r <= cke_n_s1_r;
            lbo_s1_r   <= burst_order_sel_in;
            lbo_s2_r   <= lbo_s1_r;
            addr_s1_r  <= addr_in;
            addr_s2_r  <= addr_s1_r;
            dq_s1_r    <= dq_in;
            dq_s2_r    <= dq_s1_r;
            state_r    <= state_nxt;
            tmr_r      <= tmr_nxt;
            asleep_out <= (state_nxt == ST_SLP);
            // burst state untouched while asleep; a pending write still completes into the array
            if (load_cyc)
            begin
                burst_act_r <= selected;
                burst_rd_r  <= wr_n_s2_r;
                if (selected)
                    addr_hi_r <= addr_s2_r[ADDR_W-1:2];
            end
            // single late write: data arrives one edge after address
            if (do_write)
                wr_pend_r <= 1'b0;
            if (!hold)
            begin
                if ((load_cyc && selected && !wr_n_s2_r && wr_any) ||
                    (adv_cyc && !burst_rd_r && wr_any))
                begin
                    wr_pend_r <= 1'b1;
                    wr_addr_r <= (load_cyc) ? addr_s2_r :
                                 acc_addr;
                    wr_be_n_r <= be_n_s2_r;
                end
            end
            // flow-through read; drivers off on writes and asleep
            dq_oe_out <= 1'b0;
            if (do_read && !sleeping && !oe_n_s2_r)
            begin
                dq_out    <= mem_r[sbsc_row(acc_addr)];
                dq_oe_out <= 1'b1;
            end
            else if (load_cyc && selected && wr_n_s2_r && !sleeping
                     && !oe_n_s2_r)
            begin
                dq_out    <= mem_r[sbsc_row(addr_s2_r)];
                dq_oe_out <= 1'b1;
            end
        end
    end

    // byte-lane writes into the array
    integer i;
    always @(posedge core_clk_in)
    begin
        if (do_write)
        begin
            for (i = 0; i < BYTE_W; i = i + 1)
            begin
                if (!wr_be_n_r[i])
                    mem_r[sbsc_row(wr_addr_r)][i*LANE_W +: LANE_W]
                        <= dq_s2_r[i*LANE_W +: LANE_W];
            end
        end
    end
endmodule

/* File: verification/sbsc_ctrl_assertions.sv */
// concurrent checks on the sram burst and sleep pins
`timescale 1ns/1ns
module sbsc_ctrl_assertions
#(
    parameter BYTE_W = 4
)
(
    input wire              core_clk_in,
    input wire              rst_n_in,
    input wire              load_advance_ctl_in,
    input wire              write_n_in,
    input wire [BYTE_W-1:0] byte_wr_n_in,
    input wire              chip_en1_n_in,
    input wire              chip_en2_in,
    input wire              chip_en3_n_in,
    input wire              out_en_n_in,
    input wire              clk_en_n_in,
    input wire              sleep_req_in,
    input wire              dq_oe_out,
    input wire              asleep_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire quiet = !sleep_req_in && !asleep_out && !clk_en_n_in;
    wire sel   = !chip_en1_n_in && chip_en2_in && !chip_en3_n_in && quiet;
    wire rd_ld = sel && !load_advance_ctl_in && write_n_in && !out_en_n_in;
    wire wr_ld = sel && !load_advance_ctl_in && !write_n_in
                 && byte_wr_n_in == {BYTE_W{1'b0}};
    property p_read_load;
        rd_ld |-> ##3 dq_oe_out;
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("read load gave no data");
    property p_read_adv;
        rd_ld ##1 (load_advance_ctl_in && quiet) |-> ##3 dq_oe_out;
    endproperty
    a_read_adv: assert property (p_read_adv)
        else $error("burst continue gave no data");
    property p_write_off;
        wr_ld |-> ##3 !dq_oe_out;
    endproperty
    a_write_off: assert property (p_write_off)
        else $error("bus driven in a write beat");
    property p_sleep_off;
        asleep_out |-> !dq_oe_out;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("bus driven while asleep");
    property p_entry;
        sleep_req_in [*5] |-> asleep_out;
    endproperty
    a_entry: assert property (p_entry)
        else $error("sleep not entered in time");
    property p_entry_early;
        $rose(sleep_req_in) |-> !asleep_out [*4];
    endproperty
    a_entry_early: assert property (p_entry_early)
        else $error("sleep entered too early");
    property p_exit;
        $fell(sleep_req_in) |-> ##3 !asleep_out;
    endproperty
    a_exit: assert property (p_exit)
        else $error("wake up too slow");
    property p_exit_hold;
        $fell(sleep_req_in) && asleep_out |-> asleep_out [*3];
    endproperty
    a_exit_hold: assert property (p_exit_hold)
        else $error("wake up too early");
    property p_no_longer;
        !sleep_req_in [*4] |-> !asleep_out;
    endproperty
    a_no_longer: assert property (p_no_longer)
        else $error("asleep without request");
endmodule
bind sbsc_ctrl sbsc_ctrl_assertions #(.BYTE_W(BYTE_W)) i_sbsc_ctrl_assertions
(
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .load_advance_ctl_in(load_advance_ctl_in), .write_n_in(write_n_in),
    .byte_wr_n_in(byte_wr_n_in), .chip_en1_n_in(chip_en1_n_in),
    .chip_en2_in(chip_en2_in), .chip_en3_n_in(chip_en3_n_in),
    .out_en_n_in(out_en_n_in), .clk_en_n_in(clk_en_n_in),
    .sleep_req_in(sleep_req_in), .dq_oe_out(dq_oe_out),
    .asleep_out(asleep_out)
);

/* File: verification/sbsc_host_model.sv */
// host controller model driving the sram pins
`timescale 1ns/1ns
module sbsc_host_model
(
    input  wire        core_clk_in,
    output reg  [19:0] addr_out,
    output reg         load_advance_ctl_out,
    output reg         write_n_out,
    output reg  [3:0]  byte_wr_n_out,
    output reg         chip_en1_n_out,
    output reg         sleep_req_out,
    output reg  [35:0] dq_out
);
    reg        wr_r = 1'b0;
    reg        pend_r = 1'b0;
    reg [35:0] pend_d_r = 36'h0;
    initial
    begin
        addr_out = 20'h0;
        load_advance_ctl_out = 1'b0;
        write_n_out = 1'b1;
        byte_wr_n_out = 4'hF;
        chip_en1_n_out = 1'b1;
        sleep_req_out = 1'b0;
        dq_out = 36'h0;
    end
    // kind 0 deselect, 1 read, 2 write, 3 advance
    task cmd(input [1:0] k, input [19:0] a, input [35:0] d);
    begin
        @(posedge core_clk_in);
        if (k != 2'h3)
            wr_r = (k == 2'h2);
        addr_out <= a;
        load_advance_ctl_out <= (k == 2'h3);
        chip_en1_n_out <= (k == 2'h0);
        write_n_out <= ~wr_r;
        byte_wr_n_out <= wr_r ? 4'h0 : 4'hF;
        // late data; idle bus shows the inverse of its last value
        dq_out <= pend_r ? pend_d_r : ~dq_out;
        pend_r = wr_r && (k != 2'h0);
        pend_d_r = d;
    end
    endtask
    // callers drain pending accesses before raising the request
    task set_sleep(input v);
    begin
        @(posedge core_clk_in);
        sleep_req_out <= v;
    end
    endtask
endmodule

/* File: verification/sbsc_ctrl_test.sv */
// self-checking bench for burst order and sleep control
`timescale 1ns/1ns
module sbsc_ctrl_test;
    reg         core_clk_r;
    reg         rst_n_r;
    reg         order_r;
    reg         oe_n_r;
    reg         cke_n_r;
    wire [19:0] addr;
    wire        load_advance_ctl;
    wire        wr_n;
    wire [3:0]  bw_n;
    wire        ce1_n;
    wire        sleep;
    wire [35:0] dq_w;
    wire [35:0] dq_r;
    wire        oe;
    wire        asleep;
    integer     error_cnt = 0;
    integer     checks = 0;
    logic [35:0] rd_q[$];
    sbsc_host_model i_sbsc_host_model
    (
        .core_clk_in(core_clk_r), .addr_out(addr),
        .load_advance_ctl_out(load_advance_ctl), .write_n_out(wr_n),
        .byte_wr_n_out(bw_n), .chip_en1_n_out(ce1_n),
        .sleep_req_out(sleep), .dq_out(dq_w)
    );
    sbsc_ctrl i_sbsc_ctrl
    (
        .core_clk_in(core_clk_r), .rst_n_in(rst_n_r), .addr_in(addr),
        .load_advance_ctl_in(load_advance_ctl), .write_n_in(wr_n), .byte_wr_n_in(bw_n),
        .chip_en1_n_in(ce1_n), .chip_en2_in(1'b1), .chip_en3_n_in(1'b0),
        .out_en_n_in(oe_n_r), .clk_en_n_in(cke_n_r),
        .burst_order_sel_in(order_r), .sleep_req_in(sleep),
        .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(oe), .asleep_out(asleep)
    );
    initial
    begin
        core_clk_r = 1'b0;
        forever #4 core_clk_r = ~core_clk_r;
    end
    always @(posedge core_clk_r)
        if (oe === 1'b1)
            rd_q.push_back(dq_r);
    function [35:0] pat(input [19:0] a);
        pat = {16'hC3C3, a};
    endfunction
    task check(input string name, input [35:0] got, input [35:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task drain(input integer n);
        repeat (n) i_sbsc_host_model.cmd(2'h0, 20'h0, 36'h0);
    endtask
    task wait_sleep(input v);
        integer n;
    begin
        n = 0;
        while (asleep !== v && n < 8)
        begin
            @(posedge core_clk_r);
            n = n + 1;
        end
        if (asleep !== v)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value sleep wait expected %b", v);
            tally_and_finish;
        end
    end
    endtask
    // write burst from base, then a five beat read burst from base+st
    task t_burst(input ord, input [19:0] base, input [1:0] st);
        integer   k;
        reg [1:0] lo;
    begin
        order_r <= ord;
        drain(3);
        rd_q.delete();
        i_sbsc_host_model.cmd(2'h2, base, pat(base));
        for (k = 1; k < 4; k = k + 1)
            i_sbsc_host_model.cmd(2'h3, 20'h0, pat(base + k));
        drain(2);
        i_sbsc_host_model.cmd(2'h1, base + st, 36'h0);
        for (k = 1; k < 5; k = k + 1)
            i_sbsc_host_model.cmd(2'h3, 20'hFFFFF, 36'h0);
        drain(6);
        check("beats", 36'(rd_q.size()), 36'h5);
        for (k = 0; k < 5; k = k + 1)
        begin
            lo = ord ? (st ^ k[1:0]) : (st + k[1:0]);
            check("beat", rd_q[k], pat(base + lo));
        end
        check("wrap", rd_q[4], pat(base + st));
    end
    endtask
    // reads with output enable off, then a read under clock suspend
    task t_mask;
    begin
        drain(3);
        rd_q.delete();
        oe_n_r <= 1'b1;
        i_sbsc_host_model.cmd(2'h1, 20'h00040, 36'h0);
        i_sbsc_host_model.cmd(2'h3, 20'h0, 36'h0);
        drain(1);
        oe_n_r <= 1'b0;
        cke_n_r <= 1'b1;
        i_sbsc_host_model.cmd(2'h1, 20'h00040, 36'h0);
        drain(1);
        cke_n_r <= 1'b0;
        drain(6);
        check("masked beats", 36'(rd_q.size()), 36'h0);
    end
    endtask
    task t_sleep;
    begin
        i_sbsc_host_model.cmd(2'h2, 20'h00300, pat(20'h00300));
        drain(4);
        rd_q.delete();
        i_sbsc_host_model.set_sleep(1'b1);
        wait_sleep(1'b1);
        i_sbsc_host_model.cmd(2'h2, 20'h00300, 36'h0);
        i_sbsc_host_model.cmd(2'h1, 20'h00300, 36'h0);
        drain(4);
        check("asleep", {35'h0, asleep}, 36'h1);
        check("sleep reads", 36'(rd_q.size()), 36'h0);
        i_sbsc_host_model.set_sleep(1'b0);
        wait_sleep(1'b0);
        drain(2);
        i_sbsc_host_model.cmd(2'h1, 20'h00300, 36'h0);
        drain(6);
        check("kept count", 36'(rd_q.size()), 36'h1);
        check("kept data", rd_q[0], pat(20'h00300));
    end
    endtask
    initial
    begin
        rst_n_r = 1'b0;
        order_r = 1'b0;
        oe_n_r = 1'b0;
        cke_n_r = 1'b0;
        repeat (5) @(posedge core_clk_r);
        rst_n_r <= 1'b1;
        drain(4);
        t_burst(1'b0, 20'h00040, 2'h2);
        t_burst(1'b1, 20'h00080, 2'h1);
        t_burst(1'b1, 20'h000C0, 2'h3);
        t_mask;
        t_sleep;
        tally_and_finish;
    end
endmodule
